// ---- shared/dcc_consts.svh ----
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// ------------------------------------------------------------
// register offsets (word index on the register port)
// ------------------------------------------------------------
`define DCC_OFS_CTRL 4'h0
`define DCC_OFS_PAD 4'h1
`define DCC_OFS_CNT 4'h2
`define DCC_OFS_LAST 4'h3
`define DCC_OFS_BASE_A 4'h4
`define DCC_OFS_BASE_B 4'h5
`define DCC_OFS_STAT 4'h6
`define DCC_OFS_MASK 4'h7

// ------------------------------------------------------------
// channel control field positions
// ------------------------------------------------------------
`define DCC_CTRL_ON 15
`define DCC_CTRL_SIZE 14
`define DCC_CTRL_DIR 13
`define DCC_CTRL_HALF 12
`define DCC_CTRL_DUMMY_WR 11
`define DCC_CTRL_WALK_HI 5
`define DCC_CTRL_WALK_LO 4
`define DCC_CTRL_MODE_HI 1
`define DCC_CTRL_MODE_LO 0

// ------------------------------------------------------------
// count field, status bits, reset values
// ------------------------------------------------------------
`define DCC_CNT_HI 9
`define DCC_STAT_BLOCK 0
`define DCC_STAT_WALK_ERR 1
`define DCC_STAT_W 2
`define DCC_RST_WORD 16'h0000
`define DCC_RST_STAT 2'h0
`define DCC_RST_CNT 10'h000
`define DCC_STEP_BYTE 16'h0001
`define DCC_STEP_WORD 16'h0002

`endif

// ---- shared/dcc_pkg.sv ----
package dcc_pkg;

	typedef enum logic [1:0] {
		DCC_AW_POSTINC = 2'h0,
		DCC_AW_NOINC = 2'h1,
		DCC_AW_PERIPH = 2'h2,
		DCC_AW_RSVD = 2'h3
	} dcc_walk_t;

	typedef enum logic [1:0] {
		DCC_OP_CONT = 2'h0,
		DCC_OP_ONESHOT = 2'h1,
		DCC_OP_CONT_PP = 2'h2,
		DCC_OP_ONESHOT_PP = 2'h3
	} dcc_opmode_t;

	typedef enum {
		DCC_ST_IDLE,
		DCC_ST_RD,
		DCC_ST_CAP,
		DCC_ST_WR
	} dcc_state_t;

endpackage

// ---- shared/dcc_walk_if.sv ----
`timescale 1ns/100ps
interface dcc_walk_if;
	import dcc_pkg::*;
	dcc_walk_t walk;
	logic byte_sz;
	logic buf_sel;
	logic restart;
	logic step;
	logic [15:0] base_a;
	logic [15:0] base_b;
	logic [15:0] index;
	logic [15:0] offset;
	logic [15:0] addr;
	modport ctl (output walk, byte_sz, buf_sel, restart, step, base_a, base_b, index,
		input offset, addr);
	modport gen (input walk, byte_sz, buf_sel, restart, step, base_a, base_b, index,
		output offset, addr);
endinterface

// ---- verilog/dcc_addr_gen.sv ----
`timescale 1ns/100ps
`include "dcc_consts.svh"
module dcc_addr_gen
	import dcc_pkg::*;
(
	input wire logic core_clk_i, // system clock
	input wire logic resetn_i, // sync reset, active low
	input wire logic ce_i, // clock enable
	dcc_walk_if.gen w // walk control from the channel
);
	logic [15:0] off_r;
	logic [15:0] off_nxt;
	logic [15:0] base;

	always_comb begin
		off_nxt = off_r;
		if (w.restart) begin
			off_nxt = `DCC_RST_WORD;
		end else if (w.step && w.walk == DCC_AW_POSTINC) begin
			off_nxt = off_r + (w.byte_sz ? `DCC_STEP_BYTE : `DCC_STEP_WORD); // R14
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			off_r <= `DCC_RST_WORD;
		end else if (ce_i) begin
			off_r <= off_nxt;
		end
	end

	// ------------------------------------------------------------
	// address select
	// ------------------------------------------------------------
	// peripheral indirect: the peripheral supplies the offset itself
	assign base = w.buf_sel ? w.base_b : w.base_a;
	assign w.offset = off_r;
	assign w.addr = (w.walk == DCC_AW_PERIPH) ? base + w.index : base + off_r; // R6

endmodule // dcc_addr_gen

// ---- verilog/dcc_channel.sv ----
`timescale 1ns/100ps
`include "dcc_consts.svh"
// What this block does
// R1: control register holds on, size, direction, modes
// R2: size bit one moves byte, zero word
// R3: direction one reads RAM, writes peripheral
// R4: half bit raises block interrupt midway
// R5: null mode writes zero to peripheral too
// R6: address mode: postinc, fixed, peripheral indirect
// R7: operating mode: one-shot/continuous, ping-pong or not
// R8: sixteen-bit peripheral address register, resets zero
// R9: software avoids address/count writes while enabled
// R10: ten-bit count, upper bits zero, count+1
// R11: read-only last RAM address, resets zero
// R12: unused control bits read zero
// R13: ping-pong swaps buffers; one-shot clears enable
// R14: postinc advances one per byte, two per word
module dcc_channel
	import dcc_pkg::*;
(
	input wire logic core_clk_i, // system clock, 250 MHz
	input wire logic resetn_i, // sync reset, active low
	input wire logic ce_i, // clock enable, freezes all state
	input wire logic [3:0] reg_addr_i, // register index
	input wire logic [15:0] reg_wdata_i, // register write data
	input wire logic reg_we_i, // register write strobe
	input wire logic reg_re_i, // register read strobe
	output logic [15:0] reg_rdata_o, // read data, cycle after strobe
	output logic irq_o, // level interrupt
	input wire logic periph_req_i, // peripheral transfer request pulse
	input wire logic [15:0] periph_index_i, // offset for peripheral indirect
	output logic [15:0] periph_addr_o, // peripheral address
	output logic periph_re_o, // peripheral read strobe
	output logic periph_we_o, // peripheral write strobe
	output logic [15:0] periph_wdata_o, // peripheral write data
	input wire logic [15:0] periph_rdata_i, // peripheral read data
	output logic [15:0] ram_addr_o, // DMA RAM address
	output logic ram_re_o, // DMA RAM read strobe
	output logic ram_we_o, // DMA RAM write strobe
	output logic [15:0] ram_wdata_o, // DMA RAM write data
	input wire logic [15:0] ram_rdata_i, // DMA RAM read data
	output logic byte_o // transfer is a single byte
);
	dcc_walk_if w ();

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic on_r, on_nxt, size_r, size_nxt, dir_r, dir_nxt, half_r, half_nxt;
	logic dummy_wr_r, dummy_wr_nxt;
	dcc_walk_t walk_r, walk_nxt;
	dcc_opmode_t mode_r, mode_nxt;
	logic [15:0] pad_r, pad_nxt, last_r, last_nxt, base_a_r, base_a_nxt, base_b_r, base_b_nxt;
	logic [`DCC_CNT_HI:0] cnt_r, cnt_nxt;
	logic [`DCC_STAT_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
	logic [15:0] rdata_nxt;
	logic irq_nxt, hw_off, ctrl_wr, start;

	assign ctrl_wr = reg_we_i && reg_addr_i == `DCC_OFS_CTRL;
	assign start = ctrl_wr && reg_wdata_i[`DCC_CTRL_ON] && !on_r;

	always_comb begin
		on_nxt = hw_off ? 1'b0 : on_r;
		size_nxt = size_r;
		dir_nxt = dir_r;
		half_nxt = half_r;
		dummy_wr_nxt = dummy_wr_r;
		walk_nxt = walk_r;
		mode_nxt = mode_r;
		pad_nxt = pad_r;
		cnt_nxt = cnt_r;
		base_a_nxt = base_a_r;
		base_b_nxt = base_b_r;
		mask_nxt = mask_r;
		last_nxt = (ram_re_o || ram_we_o) ? ram_addr_o : last_r; // R11
		rdata_nxt = `DCC_RST_WORD;
		if (reg_we_i) begin
			unique case (reg_addr_i)
				`DCC_OFS_CTRL: begin
					on_nxt = reg_wdata_i[`DCC_CTRL_ON]; // R1
					size_nxt = reg_wdata_i[`DCC_CTRL_SIZE];
					dir_nxt = reg_wdata_i[`DCC_CTRL_DIR];
					half_nxt = reg_wdata_i[`DCC_CTRL_HALF];
					dummy_wr_nxt = reg_wdata_i[`DCC_CTRL_DUMMY_WR];
					walk_nxt = dcc_walk_t'(reg_wdata_i[`DCC_CTRL_WALK_HI:`DCC_CTRL_WALK_LO]);
					mode_nxt = dcc_opmode_t'(reg_wdata_i[`DCC_CTRL_MODE_HI:`DCC_CTRL_MODE_LO]);
				end
				`DCC_OFS_PAD: pad_nxt = reg_wdata_i; // R8
				`DCC_OFS_CNT: cnt_nxt = reg_wdata_i[`DCC_CNT_HI:0]; // R10
				`DCC_OFS_BASE_A: base_a_nxt = reg_wdata_i;
				`DCC_OFS_BASE_B: base_b_nxt = reg_wdata_i;
				`DCC_OFS_MASK: mask_nxt = reg_wdata_i[`DCC_STAT_W-1:0];
				default: ; // last address and status are read-only; others unmapped
			endcase
		end
		// a read clears the sticky bits, but an event in the same cycle stays set
		if (reg_re_i && reg_addr_i == `DCC_OFS_STAT) begin
			stat_nxt = ev;
		end else begin
			stat_nxt = stat_r | ev;
		end
		if (reg_re_i) begin
			unique case (reg_addr_i)
				`DCC_OFS_CTRL: begin
					rdata_nxt[`DCC_CTRL_ON] = on_r; // R12
					rdata_nxt[`DCC_CTRL_SIZE] = size_r;
					rdata_nxt[`DCC_CTRL_DIR] = dir_r;
					rdata_nxt[`DCC_CTRL_HALF] = half_r;
					rdata_nxt[`DCC_CTRL_DUMMY_WR] = dummy_wr_r;
					rdata_nxt[`DCC_CTRL_WALK_HI:`DCC_CTRL_WALK_LO] = walk_r;
					rdata_nxt[`DCC_CTRL_MODE_HI:`DCC_CTRL_MODE_LO] = mode_r;
				end
				`DCC_OFS_PAD: rdata_nxt = pad_r;
				`DCC_OFS_CNT: rdata_nxt[`DCC_CNT_HI:0] = cnt_r; // R10
				`DCC_OFS_LAST: rdata_nxt = last_r;
				`DCC_OFS_BASE_A: rdata_nxt = base_a_r;
				`DCC_OFS_BASE_B: rdata_nxt = base_b_r;
				`DCC_OFS_STAT: rdata_nxt[`DCC_STAT_W-1:0] = stat_r;
				`DCC_OFS_MASK: rdata_nxt[`DCC_STAT_W-1:0] = mask_r;
				default: rdata_nxt = `DCC_RST_WORD;
			endcase
		end
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			on_r <= 1'b0;
			size_r <= 1'b0;
			dir_r <= 1'b0;
			half_r <= 1'b0;
			dummy_wr_r <= 1'b0;
			walk_r <= DCC_AW_POSTINC;
			mode_r <= DCC_OP_CONT;
			pad_r <= `DCC_RST_WORD;
			cnt_r <= `DCC_RST_CNT;
			last_r <= `DCC_RST_WORD;
			base_a_r <= `DCC_RST_WORD;
			base_b_r <= `DCC_RST_WORD;
			stat_r <= `DCC_RST_STAT;
			mask_r <= `DCC_RST_STAT;
			reg_rdata_o <= `DCC_RST_WORD;
			irq_o <= 1'b0;
		end else if (ce_i) begin
			on_r <= on_nxt;
			size_r <= size_nxt;
			dir_r <= dir_nxt;
			half_r <= half_nxt;
			dummy_wr_r <= dummy_wr_nxt;
			walk_r <= walk_nxt;
			mode_r <= mode_nxt;
			pad_r <= pad_nxt;
			cnt_r <= cnt_nxt;
			last_r <= last_nxt;
			base_a_r <= base_a_nxt;
			base_b_r <= base_b_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			reg_rdata_o <= rdata_nxt;
			irq_o <= irq_nxt;
		end
	end

	// ------------------------------------------------------------
	// transfer sequencer
	// ------------------------------------------------------------
	// the sequencer acts on the request only from idle; a request
	// arriving mid-transfer is dropped, so peripherals pace at >= 4 cycles
	dcc_state_t st_r, st_nxt;
	logic [`DCC_CNT_HI:0] done_r, done_nxt;
	logic buf_r, buf_nxt;
	logic [15:0] data;
	logic p_re_nxt, p_we_nxt, r_re_nxt, r_we_nxt, byte_nxt, blk_end;
	logic [15:0] p_addr_nxt, p_wd_nxt, r_addr_nxt, r_wd_nxt;

	assign data = dir_r ? ram_rdata_i : periph_rdata_i; // R3
	assign blk_end = done_r == cnt_r; // R10

	always_comb begin
		st_nxt = st_r;
		done_nxt = start ? `DCC_RST_CNT : done_r;
		buf_nxt = start ? 1'b0 : buf_r;
		p_re_nxt = 1'b0;
		p_we_nxt = 1'b0;
		r_re_nxt = 1'b0;
		r_we_nxt = 1'b0;
		byte_nxt = byte_o;
		p_addr_nxt = periph_addr_o;
		p_wd_nxt = periph_wdata_o;
		r_addr_nxt = ram_addr_o;
		r_wd_nxt = ram_wdata_o;
		ev = `DCC_RST_STAT;
		hw_off = 1'b0;
		w.step = 1'b0;
		w.restart = start;
		unique case (st_r)
			DCC_ST_IDLE: begin
				if (on_r && periph_req_i && !ctrl_wr) begin
					if (walk_r == DCC_AW_RSVD) begin
						ev[`DCC_STAT_WALK_ERR] = 1'b1;
					end else begin
						byte_nxt = size_r; // R2
						p_addr_nxt = pad_r; // R8
						r_addr_nxt = w.addr;
						r_re_nxt = dir_r; // R3
						p_re_nxt = !dir_r; // R3
						st_nxt = DCC_ST_RD;
					end
				end
			end
			DCC_ST_RD: st_nxt = DCC_ST_CAP;
			DCC_ST_CAP: begin
				if (dir_r) begin
					p_we_nxt = 1'b1; // R3
					p_wd_nxt = size_r ? {8'h00, data[7:0]} : data; // R2
				end else begin
					r_we_nxt = 1'b1; // R3
					r_wd_nxt = size_r ? {8'h00, data[7:0]} : data; // R2
					if (dummy_wr_r) begin
						p_we_nxt = 1'b1; // R5
						p_wd_nxt = `DCC_RST_WORD; // R5
					end
				end
				st_nxt = DCC_ST_WR;
			end
			DCC_ST_WR: begin
				w.step = 1'b1;
				done_nxt = done_r + 10'h001;
				if (half_r && done_r == (cnt_r >> 1)) begin
					ev[`DCC_STAT_BLOCK] = 1'b1; // R4
				end
				if (blk_end) begin
					ev[`DCC_STAT_BLOCK] = ev[`DCC_STAT_BLOCK] || !half_r; // R4
					done_nxt = `DCC_RST_CNT;
					w.restart = 1'b1;
					if (mode_r == DCC_OP_CONT_PP || mode_r == DCC_OP_ONESHOT_PP) begin
						buf_nxt = !buf_r; // R13
					end
					// R7
					if (mode_r == DCC_OP_ONESHOT ||
						(mode_r == DCC_OP_ONESHOT_PP && buf_r)) begin
						hw_off = 1'b1; // R13
					end
				end
				st_nxt = DCC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			st_r <= DCC_ST_IDLE;
			done_r <= `DCC_RST_CNT;
			buf_r <= 1'b0;
			periph_re_o <= 1'b0;
			periph_we_o <= 1'b0;
			ram_re_o <= 1'b0;
			ram_we_o <= 1'b0;
			byte_o <= 1'b0;
			periph_addr_o <= `DCC_RST_WORD;
			periph_wdata_o <= `DCC_RST_WORD;
			ram_addr_o <= `DCC_RST_WORD;
			ram_wdata_o <= `DCC_RST_WORD;
		end else if (ce_i) begin
			st_r <= st_nxt;
			done_r <= done_nxt;
			buf_r <= buf_nxt;
			periph_re_o <= p_re_nxt;
			periph_we_o <= p_we_nxt;
			ram_re_o <= r_re_nxt;
			ram_we_o <= r_we_nxt;
			byte_o <= byte_nxt;
			periph_addr_o <= p_addr_nxt;
			periph_wdata_o <= p_wd_nxt;
			ram_addr_o <= r_addr_nxt;
			ram_wdata_o <= r_wd_nxt;
		end
	end

	assign w.walk = walk_r;
	assign w.byte_sz = size_r;
	assign w.buf_sel = buf_r;
	assign w.base_a = base_a_r;
	assign w.base_b = base_b_r;
	assign w.index = periph_index_i;

	dcc_addr_gen u_walk (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.w(w)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	ctrl_zero_bits_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i || !ce_i) // R12
		reg_re_i && reg_addr_i == `DCC_OFS_CTRL |=> reg_rdata_o[10:6] == 5'h00 && reg_rdata_o[3:2] == 2'h0)
		else $error("control reserved bits not zero");
	cnt_upper_zero_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i || !ce_i) // R10
		reg_re_i && reg_addr_i == `DCC_OFS_CNT |=> reg_rdata_o[15:10] == 6'h00)
		else $error("count upper bits not zero");
	dir_source_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i || !ce_i) // R3
		(ram_re_o |-> dir_r && !periph_re_o) and (ram_we_o |-> !dir_r))
		else $error("transfer direction wrong");
	null_write_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i || !ce_i) // R5
		ram_we_o && dummy_wr_r |-> periph_we_o && periph_wdata_o == 16'h0000)
		else $error("null write missing");
	byte_lane_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i || !ce_i) // R2
		(ram_we_o || periph_we_o) && byte_o |-> (ram_we_o ? ram_wdata_o[15:8] : periph_wdata_o[15:8])
		== 8'h00 || (periph_we_o && dummy_wr_r))
		else $error("byte transfer carries upper byte");
	walk_step_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i || !ce_i) // R14
		st_r == DCC_ST_WR && !blk_end && walk_r == DCC_AW_POSTINC |=>
		w.offset == $past(w.offset) + (size_r ? 16'h0001 : 16'h0002))
		else $error("post increment step wrong");
	oneshot_off_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i || !ce_i) // R13
		st_r == DCC_ST_WR && blk_end && mode_r == DCC_OP_ONESHOT && !ctrl_wr |=> !on_r)
		else $error("one-shot left channel on");
	last_addr_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i || !ce_i) // R11
		ram_re_o || ram_we_o |=> last_r == $past(ram_addr_o))
		else $error("last RAM address not captured");
	periph_addr_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i || !ce_i) // R8
		periph_re_o |-> (periph_addr_o == pad_r) ##2 (periph_we_o == dummy_wr_r))
		else $error("peripheral address not from register");

endmodule // dcc_channel

// ---- verif/dcc_far_model.sv ----
`timescale 1ns/100ps
module dcc_far_model (
	input wire logic core_clk_i, // system clock
	input wire logic [15:0] ram_addr_i, // dma ram address
	input wire logic ram_re_i, // dma ram read strobe
	input wire logic ram_we_i, // dma ram write strobe
	input wire logic [15:0] ram_wdata_i, // dma ram write data
	output logic [15:0] ram_rdata_o, // dma ram read data
	input wire logic [15:0] periph_addr_i, // peripheral address
	input wire logic periph_re_i, // peripheral read strobe
	input wire logic periph_we_i, // peripheral write strobe
	input wire logic [15:0] periph_wdata_i, // peripheral write data
	input wire logic byte_i, // byte transfer flag
	output logic [15:0] periph_rdata_o // peripheral read data
);
	logic [15:0] ram_mem [0:63];
	logic [1:0] ram_hold;
	logic [1:0] per_hold;
	logic [7:0] rd_n;
	logic [15:0] pw_addr;
	logic [15:0] pw_data;
	logic pw_byte;
	int pw_count;

	initial begin
		for (int i = 0; i < 64; i++) ram_mem[i] = 16'h3c00 + 16'(i);
		ram_rdata_o = 16'h0000;
		periph_rdata_o = 16'h0000;
		ram_hold = 2'h0;
		per_hold = 2'h0;
		rd_n = 8'h00;
		pw_count = 0;
	end

	// ------------------------------------------------------------
	// read data held four cycles, then toggled every cycle so stale data reads inverted on alternate cycles
	// ------------------------------------------------------------
	always @(posedge core_clk_i) begin
		if (ram_re_i) begin
			ram_rdata_o <= ram_mem[ram_addr_i[5:0]];
			ram_hold <= 2'h3;
		end else if (ram_hold != 2'h0) ram_hold <= ram_hold - 2'h1;
		else ram_rdata_o <= ~ram_rdata_o;
		if (ram_we_i) ram_mem[ram_addr_i[5:0]] <= ram_wdata_i;
		if (periph_re_i) begin
			periph_rdata_o <= {8'h5a, rd_n};
			rd_n <= rd_n + 8'h01;
			per_hold <= 2'h3;
		end else if (per_hold != 2'h0) per_hold <= per_hold - 2'h1;
		else periph_rdata_o <= ~periph_rdata_o;
		if (periph_we_i) begin
			pw_addr <= periph_addr_i;
			pw_data <= periph_wdata_i;
			pw_byte <= byte_i;
			pw_count <= pw_count + 1;
		end
	end
endmodule // dcc_far_model

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	import dcc_pkg::*;
	typedef struct packed {logic [3:0] a; logic [15:0] w; logic [15:0] e;} dcc_row_t;
	logic clk, rst_n, ce, we, re, req, irq, pre, pwe, rre, rwe, byt;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, pidx, paddr, pwdata, prdata, raddr, rwdata, rrdata, v;
	int err_count, checks;
	dcc_row_t rows [6] = '{'{4'h0, 16'h5733, 16'h5033}, '{4'h1, 16'ha5c3, 16'ha5c3},
		'{4'h2, 16'hffff, 16'h03ff}, '{4'h3, 16'h1234, 16'h0000},
		'{4'h7, 16'h0003, 16'h0003}, '{4'h9, 16'h00ff, 16'h0000}};

	dcc_channel u_dcc_channel (.core_clk_i(clk), .resetn_i(rst_n), .ce_i(ce),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
		.reg_rdata_o(rdata), .irq_o(irq), .periph_req_i(req), .periph_index_i(pidx),
		.periph_addr_o(paddr), .periph_re_o(pre), .periph_we_o(pwe),
		.periph_wdata_o(pwdata), .periph_rdata_i(prdata), .ram_addr_o(raddr),
		.ram_re_o(rre), .ram_we_o(rwe), .ram_wdata_o(rwdata), .ram_rdata_i(rrdata),
		.byte_o(byt));
	dcc_far_model u_far (.core_clk_i(clk), .ram_addr_i(raddr), .ram_re_i(rre),
		.ram_we_i(rwe), .ram_wdata_i(rwdata), .ram_rdata_o(rrdata), .periph_addr_i(paddr),
		.periph_re_i(pre), .periph_we_i(pwe), .periph_wdata_i(pwdata), .byte_i(byt),
		.periph_rdata_o(prdata));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rc(input string n, input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		#1 chk(n, e, rdata);
	endtask
	task automatic kick(input logic [15:0] idx);
		@(posedge clk);
		req <= 1'b1;
		pidx <= idx;
		@(posedge clk);
		req <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	task automatic wait_irq();
		int i;
		for (i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk);
		if (i == 20) begin
			chk("irq_o", 16'h0001, {15'h0, irq});
			report_and_stop();
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#100000 err_count++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n, we, re, req} = 4'h0;
		ce = 1'b1;
		addr = 4'h0;
		wdata = 16'h0000;
		pidx = 16'h0000;
		err_count = 0;
		checks = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 4; a++) rc("reset value", 4'(a), 16'h0000);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rc("register row", rows[i].a, rows[i].e);
		end
		@(posedge clk);
		#1 chk("rdata after read", 16'h0000, rdata);
		// channel off while address and count change
		wr(4'h0, 16'h0000);
		wr(4'h1, 16'h0040);
		wr(4'h2, 16'h0003);
		wr(4'h4, 16'h0100);
		wr(4'h0, 16'h8801);
		for (int k = 0; k < 4; k++) begin
			kick(16'h0000);
			if (k == 2) chk("irq before block end", 16'h0000, {15'h0, irq});
		end
		wait_irq();
		for (int k = 0; k < 4; k++) chk("ram word", {8'h5a, 8'(k)}, u_far.ram_mem[2 * k]);
		chk("null writes", 16'h0004, 16'(u_far.pw_count));
		chk("null data", 16'h0000, u_far.pw_data);
		chk("null addr", 16'h0040, u_far.pw_addr);
		rc("oneshot off", 4'h0, 16'h0801);
		rc("last ram addr", 4'h3, 16'h0106);
		rc("status", 4'h6, 16'h0001);
		rc("status cleared", 4'h6, 16'h0000);
		chk("irq cleared", 16'h0000, {15'h0, irq});
		kick(16'h0000);
		chk("no transfer when off", 16'h0004, 16'(u_far.pw_count));
		// byte, ram to peripheral, fixed address, half-block event, continuous
		wr(4'h4, 16'h0105);
		wr(4'h0, 16'hf010);
		kick(16'h0000);
		kick(16'h0000);
		rc("half event", 4'h6, 16'h0001);
		kick(16'h0000);
		kick(16'h0000);
		rc("no end event", 4'h6, 16'h0000);
		rc("continuous stays on", 4'h0, 16'hf010);
		chk("byte data", 16'h0005, u_far.pw_data);
		chk("byte flag", 16'h0001, {15'h0, u_far.pw_byte});
		chk("periph addr", 16'h0040, u_far.pw_addr);
		rc("fixed last addr", 4'h3, 16'h0105);
		// peripheral indirect with ping-pong buffers
		wr(4'h0, 16'h0000);
		wr(4'h4, 16'h0100);
		wr(4'h5, 16'h0120);
		wr(4'h2, 16'h0000);
		wr(4'h0, 16'h8022);
		kick(16'h0008);
		kick(16'h0008);
		chk("buffer a", 16'h5a04, u_far.ram_mem[8]);
		chk("buffer b", 16'h5a05, u_far.ram_mem[40]);
		rc("pingpong stays on", 4'h0, 16'h8022);
		// one-shot ping-pong: one block per buffer, then the channel stops
		wr(4'h0, 16'h0000);
		wr(4'h0, 16'h8023);
		kick(16'h0008);
		kick(16'h0008);
		chk("oneshot pp buffer b", 16'h5a07, u_far.ram_mem[40]);
		rc("oneshot pp off", 4'h0, 16'h0023);
		// reserved address mode refused
		wr(4'h0, 16'h0000);
		wr(4'h0, 16'h8031);
		rc("status clear", 4'h6, 16'h0001);
		kick(16'h0000);
		rc("reserved mode", 4'h6, 16'h0002);
		chk("reserved no read", 16'h5a08, {8'h5a, u_far.rd_n});
		// a write while the clock enable is low must be lost
		@(posedge clk);
		ce <= 1'b0;
		wr(4'h1, 16'h1111);
		ce <= 1'b1;
		rc("frozen write", 4'h1, 16'h0040);
		// second reset mid-run
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk("irq after reset", 16'h0000, {15'h0, irq});
		rc("ctrl after reset", 4'h0, 16'h0000);
		rc("pad after reset", 4'h1, 16'h0000);
		rc("last after reset", 4'h3, 16'h0000);
		report_and_stop();
	end
endmodule // testbench
